/* File: core/dual_clock_flagged_fifo.sv */
`timescale 1ns/1ps
`include "fifo_defs.svh"

module dual_clock_flagged_fifo #(
   parameter int DEPTH = 65536,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_in,
   input  wire logic                    full_clear_n_in,
   input  wire logic                    partial_clear_n_in,
   input  wire logic                    reread_strobe_n_in,
   input  wire logic                    fallthrough_serial_in,
   input  wire logic                    serial_load_enable_n_in,
   input  wire logic                    offset_access_n_in,
   input  wire logic                    push_enable_n_in,
   input  wire logic                    pop_enable_n_in,
   input  wire logic                    output_enable_n_in,
   input  wire logic [`FIFO_DATA_W-1:0] push_data_in,
   output logic      [`FIFO_DATA_W-1:0] pop_data_out,
   output logic                         pop_data_oe_out,
   output logic                         space_flag_out,
   output logic                         drain_flag_out,
   output logic                         almost_full_n_out,
   output logic                         almost_empty_n_out,
   output logic                         half_level_n_out
);

   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] HALF_COUNT = (AW+1)'(DEPTH / 2);

   logic [`FIFO_DATA_W-1:0]   mem [DEPTH];
   logic [AW-1:0]             wr_ptr;
   logic [AW-1:0]             rd_ptr;
   logic [AW:0]               count;
   logic [AW:0]               next_count;
   logic                      ov;
   logic                      next_ov;
   fifo_pkg::fifo_cfg_t       cfg;
   logic [2*`OFF_W-1:0]       offsets;
   logic [`OFF_CHUNK_W-1:0]   wr_chunk;
   logic [`OFF_CHUNK_W-1:0]   rd_chunk;
   fifo_pkg::fifo_flags_t     flags;
   fifo_pkg::fifo_flags_t     next_flags;
   logic [AW:0]               level;
   logic                      clearing;
   logic                      fallthrough_mode;
   logic                      reread;
   logic                      push_fifo;
   logic                      pop_req;
   logic                      off_read;
   logic                      off_par_wr;
   logic                      off_ser_wr;
   logic                      mem_pop;
   logic                      is_full;

   assign clearing   = !full_clear_n_in || !partial_clear_n_in;
   assign fallthrough_mode       = (cfg.mode == fifo_pkg::MODE_FALLTHROUGH);
   assign reread     = !reread_strobe_n_in && !clearing;
   assign is_full    = (count == FULL_COUNT);
   assign push_fifo  = !push_enable_n_in && offset_access_n_in && !is_full && !clearing;
   assign pop_req    = !pop_enable_n_in && offset_access_n_in && !clearing;
   assign off_read   = !pop_enable_n_in && !offset_access_n_in && !clearing;
   assign off_par_wr = !push_enable_n_in && !offset_access_n_in && !clearing
                       && (cfg.method == fifo_pkg::LOAD_PARALLEL);
   assign off_ser_wr = !serial_load_enable_n_in && !offset_access_n_in && !clearing
                       && (cfg.method == fifo_pkg::LOAD_SERIAL);
   // Standard pops only on request; fallthrough refills the output word on its own
   assign mem_pop    = !reread && !off_read && (count != '0)
                       && (fallthrough_mode ? (!ov || pop_req) : pop_req);

   // Configuration is caught while the full clear is held
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg <= '{fifo_pkg::MODE_STANDARD, fifo_pkg::LOAD_PARALLEL};
      end else if (!full_clear_n_in) begin
         cfg.mode   <= fifo_pkg::timing_mode_t'(fallthrough_serial_in);
         cfg.method <= fifo_pkg::load_method_t'(offset_access_n_in);
      end
   end

   // Offset registers: empty offset low half, full offset high half
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         offsets <= {`OFF_DEF_SMALL, `OFF_DEF_SMALL};
      end else if (!full_clear_n_in) begin
         offsets <= offset_access_n_in ? {`OFF_DEF_LARGE, `OFF_DEF_LARGE}
                                       : {`OFF_DEF_SMALL, `OFF_DEF_SMALL};
      end else if (off_ser_wr) begin
         offsets <= {offsets[2*`OFF_W-2:0], fallthrough_serial_in};
      end else if (off_par_wr) begin
         offsets[wr_chunk*`FIFO_DATA_W +: `FIFO_DATA_W] <= push_data_in;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_chunk <= `ZERO_CHUNK;
      end else if (!full_clear_n_in) begin
         wr_chunk <= `ZERO_CHUNK;
      end else if (off_par_wr) begin
         wr_chunk <= wr_chunk + `ONE_CHUNK;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_chunk <= `ZERO_CHUNK;
      end else if (!full_clear_n_in) begin
         rd_chunk <= `ZERO_CHUNK;
      end else if (off_read) begin
         rd_chunk <= rd_chunk + `ONE_CHUNK;
      end
   end

   // Storage array has no reset
   always_ff @(posedge sys_clk_in) begin
      if (push_fifo) begin
         mem[wr_ptr] <= push_data_in;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
      end else if (clearing) begin
         wr_ptr <= '0;
      end else if (push_fifo) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_ptr <= '0;
      end else if (clearing || reread) begin
         rd_ptr <= '0;
      end else if (mem_pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Single clock: count is exact, no pointer crossing needed
   always_comb begin
      next_count = count;
      if (clearing) begin
         next_count = '0;
      end else if (reread) begin
         next_count = {1'b0, wr_ptr} + (AW+1)'(push_fifo);
      end else begin
         next_count = count + (AW+1)'(push_fifo) - (AW+1)'(mem_pop);
      end
   end

   always_comb begin
      next_ov = ov;
      if (clearing || reread || !fallthrough_mode) begin
         next_ov = 1'b0;
      end else if (mem_pop) begin
         next_ov = 1'b1;
      end else if (pop_req) begin
         next_ov = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ov <= 1'b0;
      end else begin
         ov <= next_ov;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pop_data_out <= `ZERO_WORD;
      end else if (clearing) begin
         pop_data_out <= `ZERO_WORD;
      end else if (off_read) begin
         pop_data_out <= offsets[rd_chunk*`FIFO_DATA_W +: `FIFO_DATA_W];
      end else if (mem_pop) begin
         pop_data_out <= mem[rd_ptr];
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pop_data_oe_out <= 1'b0;
      end else begin
         pop_data_oe_out <= !output_enable_n_in;
      end
   end

   // Flags follow the post-edge level except drain on a reread; only the almost and half flags count the fallthrough output word
   always_comb begin
      level = next_count + (AW+1)'(fallthrough_mode && next_ov);
      next_flags.space = fallthrough_mode ? (next_count == FULL_COUNT)
                              : (next_count != FULL_COUNT);
      if (reread) begin
         next_flags.drain = fallthrough_mode;
      end else begin
         next_flags.drain = fallthrough_mode ? !next_ov : (next_count != '0);
      end
      next_flags.almost_full_n  = !(32'(level) + 32'(offsets[2*`OFF_W-1:`OFF_W]) > 32'(DEPTH));
      next_flags.almost_empty_n = !(32'(level) < 32'(offsets[`OFF_W-1:0]));
      next_flags.half_level_n   = !(level > HALF_COUNT);
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      end else begin
         flags <= next_flags;
      end
   end

   assign space_flag_out     = flags.space;
   assign drain_flag_out     = flags.drain;
   assign almost_full_n_out  = flags.almost_full_n;
   assign almost_empty_n_out = flags.almost_empty_n;
   assign half_level_n_out   = flags.half_level_n;

   property p_clear_zero;
      @(posedge sys_clk_in) disable iff (rst_in)
      clearing |=> (pop_data_out == `ZERO_WORD) && (wr_ptr == '0) && (rd_ptr == '0);
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("clear left pointers or output set");

   property p_cfg_capture;
      @(posedge sys_clk_in) disable iff (rst_in)
      !full_clear_n_in |=> (cfg.mode == $past(fallthrough_serial_in))
                           && (cfg.method == $past(offset_access_n_in));
   endproperty
   a_cfg_capture: assert property (p_cfg_capture) else $error("config not captured");

   property p_partial_keeps;
      @(posedge sys_clk_in) disable iff (rst_in)
      (full_clear_n_in && !partial_clear_n_in) |=> $stable(cfg) && $stable(offsets);
   endproperty
   a_partial_keeps: assert property (p_partial_keeps) else $error("partial clear changed settings");

   property p_reread;
      @(posedge sys_clk_in) disable iff (rst_in)
      reread |=> (rd_ptr == '0) && (drain_flag_out == $past(fallthrough_mode));
   endproperty
   a_reread: assert property (p_reread) else $error("reread did not rewind");

   property p_push;
      @(posedge sys_clk_in) disable iff (rst_in)
      push_fifo |=> wr_ptr == $past(wr_ptr) + 1'b1;
   endproperty
   a_push: assert property (p_push) else $error("push did not advance write pointer");

   property p_serial;
      @(posedge sys_clk_in) disable iff (rst_in)
      off_ser_wr |=> offsets[0] == $past(fallthrough_serial_in);
   endproperty
   a_serial: assert property (p_serial) else $error("serial bit not shifted in");

   property p_oe;
      @(posedge sys_clk_in) disable iff (rst_in)
      output_enable_n_in |=> !pop_data_oe_out;
   endproperty
   a_oe: assert property (p_oe) else $error("data driven while disabled");

   property p_full_flag;
      @(posedge sys_clk_in) disable iff (rst_in)
      (!fallthrough_mode && full_clear_n_in && $past(full_clear_n_in) && is_full) |-> !space_flag_out;
   endproperty
   a_full_flag: assert property (p_full_flag) else $error("full flag missing");

   property p_empty_flag;
      @(posedge sys_clk_in) disable iff (rst_in)
      (!fallthrough_mode && full_clear_n_in && $past(full_clear_n_in) && $past(!reread) && count == '0)
      |-> !drain_flag_out;
   endproperty
   a_empty_flag: assert property (p_empty_flag) else $error("empty flag missing");

   property p_fall_through;
      @(posedge sys_clk_in) disable iff (rst_in)
      (fallthrough_mode && !ov && count == '0 && push_fifo && pop_enable_n_in && full_clear_n_in)
      ##1 (full_clear_n_in && partial_clear_n_in && reread_strobe_n_in)
      |=> !drain_flag_out;
   endproperty
   a_fall_through: assert property (p_fall_through) else $error("first word did not fall through");

   property p_std_hold;
      @(posedge sys_clk_in) disable iff (rst_in)
      (!fallthrough_mode && pop_enable_n_in && !clearing) |=> $stable(pop_data_out);
   endproperty
   a_std_hold: assert property (p_std_hold) else $error("output changed without pop");

   property p_offset_read;
      @(posedge sys_clk_in) disable iff (rst_in)
      (off_read && rd_chunk == `ZERO_CHUNK) |=> pop_data_out == $past(offsets[`FIFO_DATA_W-1:0]);
   endproperty
   a_offset_read: assert property (p_offset_read) else $error("offset readback wrong");

   property p_default_offsets;
      @(posedge sys_clk_in) disable iff (rst_in)
      !full_clear_n_in |=> offsets == ($past(offset_access_n_in) ? {`OFF_DEF_LARGE, `OFF_DEF_LARGE}
                                                                : {`OFF_DEF_SMALL, `OFF_DEF_SMALL});
   endproperty
   a_default_offsets: assert property (p_default_offsets) else $error("default offsets not loaded");

   property p_no_overfill;
      @(posedge sys_clk_in) disable iff (rst_in)
      (is_full && !clearing && !reread) |=> wr_ptr == $past(wr_ptr);
   endproperty
   a_no_overfill: assert property (p_no_overfill) else $error("write accepted while full");

   c_fall_through: cover property (@(posedge sys_clk_in) disable iff (rst_in) fallthrough_mode && mem_pop && !pop_req);
   c_reread:       cover property (@(posedge sys_clk_in) disable iff (rst_in) reread && count != '0);
   c_offset_read:  cover property (@(posedge sys_clk_in) disable iff (rst_in) off_read);
   c_full:         cover property (@(posedge sys_clk_in) disable iff (rst_in) is_full);

endmodule

/* File: core/fifo_defs.svh */
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH

`define FIFO_DATA_W    9
`define OFF_W          18
`define OFF_CHUNK_W    2
`define OFF_DEF_SMALL  18'h0007F
`define OFF_DEF_LARGE  18'h003FF
`define ZERO_WORD      9'h000
`define ZERO_OFFSETS   36'h000000000
`define ZERO_CHUNK     2'h0
`define ONE_CHUNK      2'h1

`endif

/* File: core/fifo_pkg.sv */
package fifo_pkg;

   typedef enum logic {
      MODE_STANDARD    = 1'b0,
      MODE_FALLTHROUGH = 1'b1
   } timing_mode_t;

   typedef enum logic {
      LOAD_PARALLEL = 1'b0,
      LOAD_SERIAL   = 1'b1
   } load_method_t;

   typedef struct packed {
      timing_mode_t mode;
      load_method_t method;
   } fifo_cfg_t;

   typedef struct packed {
      logic space;
      logic drain;
      logic almost_full_n;
      logic almost_empty_n;
      logic half_level_n;
   } fifo_flags_t;

endpackage

/* File: tb/stream_peer.sv */
`timescale 1ns/1ps
`include "fifo_defs.svh"

// Producer and consumer sitting on the far side of the buffer
module stream_peer (
   input  wire logic                    sys_clk_in,
   output logic                         push_enable_n_out,
   output logic      [`FIFO_DATA_W-1:0] push_data_out,
   output logic                         pop_enable_n_out
);
   initial begin
      push_enable_n_out = 1'b1;
      push_data_out = 9'h000;
      pop_enable_n_out = 1'b1;
   end

   // One word per call, then one idle edge so flags settle before checks
   task automatic push_word(input logic [`FIFO_DATA_W-1:0] d);
      push_enable_n_out = 1'b0;
      push_data_out = d;
      @(posedge sys_clk_in);
      #1;
      push_enable_n_out = 1'b1;
      // Stale data is inverted so nothing can latch it by accident
      push_data_out = ~d;
      @(posedge sys_clk_in);
      #1;
   endtask

   task automatic pop_word();
      pop_enable_n_out = 1'b0;
      @(posedge sys_clk_in);
      #1;
      pop_enable_n_out = 1'b1;
      @(posedge sys_clk_in);
      #1;
   endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "fifo_defs.svh"

module tb_top;
   localparam int DEPTH = 16;
   logic                    sys_clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    full_clear_n = 1'b1;
   logic                    partial_clear_n = 1'b1;
   logic                    reread_n = 1'b1;
   logic                    ft_si = 1'b0;
   logic                    sen_n = 1'b1;
   logic                    ld_n = 1'b1;
   logic                    oe_n = 1'b0;
   logic                    push_en_n;
   logic                    pop_en_n;
   logic [`FIFO_DATA_W-1:0] push_data;
   logic [`FIFO_DATA_W-1:0] pop_data;
   logic                    oe_out;
   fifo_pkg::fifo_flags_t   fl;
   int                      n_fail = 0;
   int                      total_checks = 0;

   always #4 sys_clk = ~sys_clk;

   stream_peer i_peer (.sys_clk_in(sys_clk), .push_enable_n_out(push_en_n), .push_data_out(push_data),
                       .pop_enable_n_out(pop_en_n));

   dual_clock_flagged_fifo #(.DEPTH(DEPTH)) i_dut (
      .sys_clk_in(sys_clk), .rst_in(rst), .full_clear_n_in(full_clear_n),
      .partial_clear_n_in(partial_clear_n), .reread_strobe_n_in(reread_n),
      .fallthrough_serial_in(ft_si), .serial_load_enable_n_in(sen_n), .offset_access_n_in(ld_n),
      .push_enable_n_in(push_en_n), .pop_enable_n_in(pop_en_n), .output_enable_n_in(oe_n),
      .push_data_in(push_data), .pop_data_out(pop_data), .pop_data_oe_out(oe_out),
      .space_flag_out(fl.space), .drain_flag_out(fl.drain), .almost_full_n_out(fl.almost_full_n),
      .almost_empty_n_out(fl.almost_empty_n), .half_level_n_out(fl.half_level_n));

   task automatic give_verdict();
      if (n_fail == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk_word(input string what, input logic [8:0] exp, input logic [8:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_flag(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Standard-mode flags for a fill level k, offsets n = m = 4
   task automatic chk_level(input int k);
      chk_flag("space", k != DEPTH, fl.space);
      chk_flag("drain", k != 0, fl.drain);
      chk_flag("almost_full_n", !(k > DEPTH - 4), fl.almost_full_n);
      chk_flag("almost_empty_n", !(k < 4), fl.almost_empty_n);
      chk_flag("half_level_n", !(k > DEPTH / 2), fl.half_level_n);
   endtask

   task automatic full_clear(input logic ft, input logic ld);
      ft_si = ft;
      ld_n = ld;
      full_clear_n = 1'b0;
      // Selection pins stay put across both clear edges
      repeat (2) @(posedge sys_clk);
      #1;
      full_clear_n = 1'b1;
      ld_n = 1'b1;
      ft_si = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic t_oe();
      oe_n = 1'b1;
      @(posedge sys_clk);
      #1;
      chk_flag("oe off", 1'b0, oe_out);
      oe_n = 1'b0;
      @(posedge sys_clk);
      #1;
      chk_flag("oe on", 1'b1, oe_out);
   endtask

   task automatic t_standard();
      full_clear(1'b0, 1'b0);
      ld_n = 1'b0;
      for (int c = 0; c < 4; c++) i_peer.push_word(c[0] ? 9'h000 : 9'h004);
      for (int c = 0; c < 4; c++) begin
         i_peer.pop_word();
         chk_word("offset chunk", c[0] ? 9'h000 : 9'h004, pop_data);
      end
      ld_n = 1'b1;
      chk_level(0);
      for (int k = 1; k <= DEPTH; k++) begin
         i_peer.push_word(9'h100 + 9'(k));
         chk_level(k);
      end
      i_peer.push_word(9'h0AA);
      chk_level(DEPTH);
      for (int k = 1; k <= DEPTH; k++) begin
         i_peer.pop_word();
         chk_word("pop data", 9'h100 + 9'(k), pop_data);
         chk_level(DEPTH - k);
      end
      i_peer.pop_word();
      chk_word("empty pop holds", 9'h110, pop_data);
   endtask

   task automatic t_partial();
      for (int k = 0; k < 3; k++) i_peer.push_word(9'h1F0);
      partial_clear_n = 1'b0;
      @(posedge sys_clk);
      #1;
      partial_clear_n = 1'b1;
      @(posedge sys_clk);
      #1;
      chk_word("cleared output", 9'h000, pop_data);
      chk_level(0);
      for (int k = 1; k <= 4; k++) i_peer.push_word(9'h060 + 9'(k));
      chk_level(4);
      repeat (2) i_peer.pop_word();
      reread_n = 1'b0;
      @(posedge sys_clk);
      #1;
      chk_flag("reread empty", 1'b0, fl.drain);
      reread_n = 1'b1;
      @(posedge sys_clk);
      #1;
      i_peer.pop_word();
      chk_word("reread data", 9'h061, pop_data);
      chk_level(3);
   endtask

   task automatic t_fallthrough();
      logic [35:0] pattern;
      pattern = {18'h00005, 18'h00003};
      full_clear(1'b1, 1'b1);
      chk_flag("ft space", 1'b0, fl.space);
      chk_flag("ft drain", 1'b1, fl.drain);
      i_peer.push_word(9'h1C3);
      @(posedge sys_clk);
      #1;
      chk_word("fall through", 9'h1C3, pop_data);
      chk_flag("ft valid", 1'b0, fl.drain);
      chk_flag("default n 1023", 1'b0, fl.almost_empty_n);
      ld_n = 1'b0;
      sen_n = 1'b0;
      for (int i = 35; i >= 0; i--) begin
         ft_si = pattern[i];
         @(posedge sys_clk);
         #1;
      end
      sen_n = 1'b1;
      ld_n = 1'b1;
      @(posedge sys_clk);
      #1;
      chk_flag("serial n low", 1'b0, fl.almost_empty_n);
      repeat (2) i_peer.push_word(9'h0F0);
      chk_flag("serial n met", 1'b1, fl.almost_empty_n);
      ld_n = 1'b0;
      i_peer.pop_word();
      ld_n = 1'b1;
      chk_word("serial readback", 9'h003, pop_data);
      reread_n = 1'b0;
      @(posedge sys_clk);
      #1;
      chk_flag("ft reread invalid", 1'b1, fl.drain);
      reread_n = 1'b1;
      @(posedge sys_clk);
      #1;
      chk_word("ft reread word", 9'h1C3, pop_data);
      chk_flag("ft reread valid", 1'b0, fl.drain);
   endtask

   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      t_oe();
      t_standard();
      t_partial();
      t_fallthrough();
      give_verdict();
   end

   initial begin
      #50000;
      n_fail++;
      give_verdict();
   end
endmodule
